/* File: shared/dmb_pkg.sv */
package dmb_pkg;

  // data memory address geometry
  localparam int ADDR_W = 12;
  localparam int OFFS_W = 8;
  localparam int BANK_W = 4;
  localparam int NIB_W = 4;

  // bank values used when the bank enable flag is clear
  localparam logic [3:0] BANK_LOW = 4'h0;
  localparam logic [3:0] BANK_HIGH = 4'hF;
  localparam logic [7:0] DIRECT_SPLIT = 8'h80;

  // decode windows of the 12-bit space
  localparam logic [11:0] RAM0_LO = 12'h000;
  localparam logic [11:0] RAM0_HI = 12'h19F;
  localparam logic [11:0] DISP_LO = 12'h1A0;
  localparam logic [11:0] DISP_HI = 12'h1FF;
  localparam logic [11:0] RAM1_LO = 12'h200;
  localparam logic [11:0] RAM1_HI = 12'h3FF;
  localparam logic [11:0] PERI_LO = 12'hF80;
  localparam logic [11:0] PERI_HI = 12'hFFF;

  // fixed-area and port-bit windows (upper operand nibble / floor)
  localparam logic [3:0] FIX_IRQ_NIB = 4'hB;
  localparam logic [3:0] FIX_PORT_NIB = 4'hF;
  localparam logic [7:0] PORT_BIT_FLOOR = 8'hC0;

  // reset values
  localparam logic RST_BANK_ENABLE = 1'b0;
  localparam logic [3:0] RST_BANK_SELECT = 4'h0;
  localparam logic [1:0] RST_STACK_BANK = 2'h0;

  typedef enum logic [3:0] {
    AM_DIR1, AM_DIR4, AM_DIR8,
    AM_IND_IX, AM_IND_IX_INC, AM_IND_IX_DEC,
    AM_IND_AUX, AM_IND_AUX_MINOR, AM_IND8_IX,
    AM_FIX_BIT, AM_PORT_BIT, AM_HIDX_BIT, AM_STACK
  } dmb_mode_t;

  typedef enum logic [1:0] {
    RGN_NONE, RGN_RAM, RGN_DISP, RGN_PERIPH
  } dmb_region_t;

  typedef struct packed {
    logic valid;
    dmb_mode_t mode;
    logic [7:0] operand;
    logic [1:0] bitNum;
    logic [3:0] hiIdx;
    logic [3:0] loIdx;
    logic [3:0] auxHi;
    logic [3:0] auxLo;
    logic [7:0] stackPointer;
  } dmb_req_t;

  typedef struct packed {
    logic valid;
    logic [11:0] addr;
    logic [1:0] bitSel;
    dmb_region_t region;
    logic fault;
  } dmb_resp_t;

endpackage : dmb_pkg

/* File: src/dmb_addr_gen.sv */
// Behaviour
// R01: every data address is 12 bits, low 8 from the instruction side, high 4 from the active bank; the code uses it only in paired- and high-index modes.
// R02: addresses 000H-19FH and 200H-3FFH are reported as general static RAM.
// R03: 1A0H-1FFH is reported as display memory and F80H-FFFH as peripheral space.
// R04: the bank select register takes only the values 0, 1, 2, 3 and 15.
// R05: on interrupt or subroutine entry the bank enable flag is saved and then cleared.
// R06: direct modes use bank 0 below 80H and bank 15 from 80H when the flag is clear, else the select value.
// R07: the far side supplies an even operand for 8-bit direct accesses.
// R08: paired-index indirect uses flag AND select; its +/- forms step only the low index afterwards.
// R09: auxiliary pair indirect always lands in bank 0.
// R10: 8-bit paired-index indirect forces bit 0 of the low index to zero.
// R11: fixed-area bit accesses reach only FB0H-FBFH and FF0H-FFFH, whatever the bank state.
// R12: port-bit indirect joins operand bits 7:2 with low index bits 3:2, low index bits 1:0 pick the bit.
// R13: high-index bit accesses use flag AND select, the high index and operand bits 3:0.
// R14: stack accesses use the stack pointer inside bank 0 to 3 chosen by the stack bank select.
// R15: the active bank is derived combinationally from the live flag and select values.
`timescale 1ns/1ps
module dmb_addr_gen #(
  parameter int SAVE_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire dmb_pkg::dmb_req_t req,
  input wire logic bankSelectWr,
  input wire logic [3:0] bankSelectData,
  input wire logic bankEnableWr,
  input wire logic bankEnableData,
  input wire logic stackBankWr,
  input wire logic [1:0] stackBankData,
  input wire logic serviceEnter,
  input wire logic serviceReturn,
  output dmb_pkg::dmb_resp_t resp,
  output logic loIdxWr,
  output logic [3:0] loIdxNew,
  output logic bankEnable,
  output logic [3:0] bankSelect,
  output logic [1:0] stackBank,
  output logic selectRejected
);
  import dmb_pkg::*;

  // bank values accepted by the select register
  function automatic logic legal_bank(input logic [3:0] v);
    legal_bank = (v <= 4'h3) || (v == BANK_HIGH); // R04
  endfunction : legal_bank

  // region decode for the registered response; the checks below compare against the window limits directly
  function automatic dmb_region_t region_of(input logic [11:0] a);
    if ((a >= RAM0_LO && a <= RAM0_HI) || (a >= RAM1_LO && a <= RAM1_HI))
      region_of = RGN_RAM; // R02
    else if (a >= DISP_LO && a <= DISP_HI)
      region_of = RGN_DISP; // R03
    else if (a >= PERI_LO && a <= PERI_HI)
      region_of = RGN_PERIPH; // R03
    else
      region_of = RGN_NONE;
  endfunction : region_of

  logic [SAVE_DEPTH-1:0] savedFlags;
  logic [3:0] activeBank;
  logic [3:0] directBank;
  logic [11:0] next_addr;
  logic [1:0] next_bitSel;
  logic next_fault;

  // live bank values; no register stage so a write is seen next access
  assign activeBank = bankEnable ? bankSelect : BANK_LOW; // R15 R08
  always_comb begin
    if (bankEnable)
      directBank = bankSelect; // R06
    else if (req.operand >= DIRECT_SPLIT)
      directBank = BANK_HIGH; // R06
    else
      directBank = BANK_LOW; // R06
  end

  // address formation per addressing mode
  always_comb begin
    next_addr = '0;
    next_bitSel = req.bitNum;
    next_fault = 1'b0;
    case (req.mode)
      AM_DIR1, AM_DIR4, AM_DIR8: begin
        // 8-bit direct relies on an even operand from the decoder
        next_addr = {directBank, req.operand}; // R01 R06 R07
      end
      AM_IND_IX, AM_IND_IX_INC, AM_IND_IX_DEC: begin
        next_addr = {activeBank, req.hiIdx, req.loIdx}; // R08
      end
      AM_IND_AUX: begin
        next_addr = {BANK_LOW, req.auxHi, req.auxLo}; // R09
      end
      AM_IND_AUX_MINOR: begin
        next_addr = {BANK_LOW, req.auxHi, req.loIdx}; // R09
      end
      AM_IND8_IX: begin
        next_addr = {activeBank, req.hiIdx, req.loIdx[3:1], 1'b0}; // R10
      end
      AM_FIX_BIT: begin
        // the bank state is never consulted here
        next_addr = {BANK_HIGH, req.operand}; // R11
        next_fault = (req.operand[7:4] != FIX_IRQ_NIB) &&
                     (req.operand[7:4] != FIX_PORT_NIB); // R11
      end
      AM_PORT_BIT: begin
        next_addr = {BANK_HIGH, req.operand[7:2], req.loIdx[3:2]}; // R12
        next_bitSel = req.loIdx[1:0]; // R12
        next_fault = (req.operand < PORT_BIT_FLOOR); // R12
      end
      AM_HIDX_BIT: begin
        next_addr = {activeBank, req.hiIdx, req.operand[3:0]}; // R13
      end
      AM_STACK: begin
        next_addr = {2'b00, stackBank, req.stackPointer}; // R14
      end
      default: begin
        next_fault = 1'b1;
      end
    endcase
  end

  // registered response toward the memory side
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resp <= '0;
    end else begin
      resp.valid <= req.valid;
      resp.addr <= next_addr; // R01
      resp.bitSel <= next_bitSel;
      resp.region <= region_of(next_addr); // R02 R03
      resp.fault <= req.valid & next_fault;
    end
  end

  // post-increment and post-decrement touch only the low index
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      loIdxWr <= 1'b0;
      loIdxNew <= '0;
    end else begin
      loIdxWr <= req.valid && (req.mode == AM_IND_IX_INC ||
                               req.mode == AM_IND_IX_DEC); // R08
      if (req.mode == AM_IND_IX_DEC)
        loIdxNew <= req.loIdx - 4'h1; // R08
      else
        loIdxNew <= req.loIdx + 4'h1; // R08
    end
  end

  // bank select register; an illegal value keeps the old one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bankSelect <= RST_BANK_SELECT;
      selectRejected <= 1'b0;
    end else begin
      selectRejected <= bankSelectWr && !legal_bank(bankSelectData); // R04
      if (bankSelectWr && legal_bank(bankSelectData))
        bankSelect <= bankSelectData; // R04
    end
  end

  // bank enable flag with a save stack for nested service entries;
  // entry beats a same-cycle software write so the save is never lost
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bankEnable <= RST_BANK_ENABLE;
      savedFlags <= '0;
    end else if (serviceEnter) begin
      savedFlags <= {savedFlags[SAVE_DEPTH-2:0], bankEnable}; // R05
      bankEnable <= 1'b0; // R05
    end else if (serviceReturn) begin
      bankEnable <= savedFlags[0];
      savedFlags <= {1'b0, savedFlags[SAVE_DEPTH-1:1]};
    end else if (bankEnableWr) begin
      bankEnable <= bankEnableData;
    end
  end

  // stack bank select; only banks 0 to 3 exist for the stack
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      stackBank <= RST_STACK_BANK;
    else if (stackBankWr)
      stackBank <= stackBankData; // R14
  end

  // ---- checks ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_direct_req;
    req.valid && (req.mode inside {AM_DIR1, AM_DIR4, AM_DIR8});
  endsequence

  property p_direct_bank;
    s_direct_req |=> resp.addr[11:8] == ($past(bankEnable) ?
      $past(bankSelect) : ($past(req.operand[7]) ? BANK_HIGH : BANK_LOW));
  endproperty
  a_direct_bank: assert property (p_direct_bank) // R06
    else $error("direct access used the wrong bank");

  property p_direct_low;
    s_direct_req |=> resp.addr[7:0] == $past(req.operand);
  endproperty
  a_direct_low: assert property (p_direct_low) // R01
    else $error("direct access low byte differs from operand");

  property p_aux_bank0;
    req.valid && (req.mode inside {AM_IND_AUX, AM_IND_AUX_MINOR})
      |=> resp.addr[11:8] == BANK_LOW;
  endproperty
  a_aux_bank0: assert property (p_aux_bank0) // R09
    else $error("auxiliary pair access left bank 0");

  property p_ind8_even;
    req.valid && req.mode == AM_IND8_IX |=> !resp.addr[0] &&
      resp.addr[11:8] == ($past(bankEnable) ? $past(bankSelect) : BANK_LOW);
  endproperty
  a_ind8_even: assert property (p_ind8_even) // R10
    else $error("8-bit indirect address not even or wrong bank");

  sequence s_step_req;
    req.valid && req.mode == AM_IND_IX_DEC;
  endsequence

  property p_step_dec;
    s_step_req |=> loIdxWr && loIdxNew == $past(req.loIdx) - 4'h1;
  endproperty
  a_step_dec: assert property (p_step_dec) // R08
    else $error("post-decrement did not step the low index");

  property p_no_step;
    req.valid && req.mode == AM_IND_IX |=> !loIdxWr;
  endproperty
  a_no_step: assert property (p_no_step) // R08
    else $error("plain indirect stepped the low index");

  property p_select_legal;
    bankSelectWr && !legal_bank(bankSelectData)
      |=> selectRejected && bankSelect == $past(bankSelect);
  endproperty
  a_select_legal: assert property (p_select_legal) // R04
    else $error("illegal bank value was accepted");

  sequence s_enter;
    serviceEnter;
  endsequence

  property p_enter_save;
    s_enter |=> !bankEnable && savedFlags[0] == $past(bankEnable);
  endproperty
  a_enter_save: assert property (p_enter_save) // R05
    else $error("service entry did not save and clear the flag");

  property p_fixed_area;
    resp.valid && !resp.fault && $past(req.mode) == AM_FIX_BIT
      |-> resp.addr[11:8] == BANK_HIGH &&
          (resp.addr[7:4] == FIX_IRQ_NIB || resp.addr[7:4] == FIX_PORT_NIB);
  endproperty
  a_fixed_area: assert property (p_fixed_area) // R11
    else $error("fixed-area access outside its window");

  property p_port_bit;
    req.valid && req.mode == AM_PORT_BIT |=>
      resp.addr[1:0] == $past(req.loIdx[3:2]) &&
      resp.bitSel == $past(req.loIdx[1:0]);
  endproperty
  a_port_bit: assert property (p_port_bit) // R12
    else $error("port bit address or bit select mismatch");

  property p_hidx;
    req.valid && req.mode == AM_HIDX_BIT |=>
      resp.addr[7:0] == {$past(req.hiIdx), $past(req.operand[3:0])};
  endproperty
  a_hidx: assert property (p_hidx) // R13
    else $error("high index bit address mismatch");

  property p_stack;
    req.valid && req.mode == AM_STACK |=>
      resp.addr == {2'b00, $past(stackBank), $past(req.stackPointer)};
  endproperty
  a_stack: assert property (p_stack) // R14
    else $error("stack address outside selected bank");

  property p_region;
    resp.valid && resp.addr >= DISP_LO && resp.addr <= DISP_HI
      |-> resp.region == RGN_DISP;
  endproperty
  a_region: assert property (p_region) // R03
    else $error("display window mis-decoded");

  property p_live_bank;
    bankSelectWr && legal_bank(bankSelectData) && !serviceEnter ##1
      bankEnable && req.valid && req.mode == AM_HIDX_BIT
      |=> resp.addr[11:8] == $past(bankSelectData, 2);
  endproperty
  a_live_bank: assert property (p_live_bank) // R15
    else $error("new bank select not used on the next access");

endmodule : dmb_addr_gen

/* File: verif/dmb_regfile_model.sv */
`timescale 1ns/1ps
// register file behind the paired index: keeps the low index that the
// generator steps, or a fresh value loaded by the decoder
module dmb_regfile_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic loIdxWr,
  input wire logic [3:0] loIdxNew,
  input wire logic loadWr,
  input wire logic [3:0] loadData,
  output logic [3:0] loIdxReg
);
  // write-back wins: the step belongs to the instruction already issued
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      loIdxReg <= 4'h0;
    end else if (loIdxWr) begin
      loIdxReg <= loIdxNew;
    end else if (loadWr) begin
      loIdxReg <= loadData;
    end
  end
endmodule : dmb_regfile_model

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import dmb_pkg::*;
  typedef struct packed {
    dmb_resp_t r;
    logic w;
    logic [3:0] n;
  } dmb_note_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  dmb_req_t req = '0;
  logic bankSelectWr = 1'b0, bankEnableWr = 1'b0, stackBankWr = 1'b0;
  logic [3:0] bankSelectData = 4'h0, loadData = 4'h0, loIdxNew, bankSelect;
  logic bankEnableData = 1'b0, serviceEnter = 1'b0, serviceReturn = 1'b0;
  logic [1:0] stackBankData = 2'h0, stackBank;
  logic loadWr = 1'b0, loIdxWr, bankEnable, selectRejected;
  logic [3:0] loIdxReg;
  dmb_resp_t resp;
  // shadow of the bank state, as the bench expects it
  logic f = 1'b0, rej = 1'b0;
  logic [3:0] s = 4'h0;
  logic [1:0] sb = 2'h0;
  logic stk[$];
  dmb_note_t notes[$];
  dmb_note_t nt;
  logic [63:0] w;
  int miscompares = 0, n_compared = 0, seed = 12;

  dmb_addr_gen #(.SAVE_DEPTH(8)) dmb_addr_gen_i (.clk_sys, .rst, .req,
    .bankSelectWr, .bankSelectData, .bankEnableWr, .bankEnableData,
    .stackBankWr, .stackBankData, .serviceEnter, .serviceReturn, .resp,
    .loIdxWr, .loIdxNew, .bankEnable, .bankSelect, .stackBank,
    .selectRejected);
  dmb_regfile_model dmb_regfile_model_i (.clk_sys, .rst, .loIdxWr,
    .loIdxNew, .loadWr, .loadData, .loIdxReg);

  always #20 clk_sys = ~clk_sys;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task print_verdict;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // expected answer, built from the bank state seen at the request edge
  function automatic dmb_note_t predict(dmb_req_t q);
    dmb_note_t e;
    logic [3:0] b;
    logic [11:0] a;
    e = '0;
    b = f ? s : 4'h0;
    e.r.valid = 1'b1;
    e.r.bitSel = q.bitNum;
    case (q.mode)
      AM_DIR1, AM_DIR4, AM_DIR8:
        a = {f ? s : {4{q.operand[7]}}, q.operand};
      AM_IND_IX, AM_IND_IX_INC, AM_IND_IX_DEC:
        a = {b, q.hiIdx, q.loIdx};
      AM_IND_AUX: a = {4'h0, q.auxHi, q.auxLo};
      AM_IND_AUX_MINOR: a = {4'h0, q.auxHi, q.loIdx};
      AM_IND8_IX: a = {b, q.hiIdx, q.loIdx[3:1], 1'b0};
      AM_FIX_BIT: begin
        a = {4'hF, q.operand};
        e.r.fault = !(q.operand[7:4] inside {4'hB, 4'hF});
      end
      AM_PORT_BIT: begin
        a = {4'hF, q.operand[7:2], q.loIdx[3:2]};
        e.r.bitSel = q.loIdx[1:0];
        e.r.fault = q.operand < 8'hC0;
      end
      AM_HIDX_BIT: a = {b, q.hiIdx, q.operand[3:0]};
      default: a = {2'b00, sb, q.stackPointer};
    endcase
    e.r.addr = a;
    // the display window sits inside the ram span, so test it first
    if (a >= 12'h1A0 && a <= 12'h1FF) begin
      e.r.region = RGN_DISP;
    end else if (a <= 12'h3FF) begin
      e.r.region = RGN_RAM;
    end else if (a >= 12'hF80) begin
      e.r.region = RGN_PERIPH;
    end else begin
      e.r.region = RGN_NONE;
    end
    e.w = q.mode inside {AM_IND_IX_INC, AM_IND_IX_DEC};
    e.n = (q.mode == AM_IND_IX_INC) ? q.loIdx + 4'h1 : q.loIdx - 4'h1;
    return e;
  endfunction : predict

  // answers land one edge after the request; read them at the falling edge
  always @(negedge clk_sys) begin
    if (!rst && resp.valid === 1'b1) begin
      nt = (notes.size() > 0) ? notes.pop_front() : '0;
      chk(32'(resp), 32'(nt.r));
      chk(32'(loIdxWr), 32'(nt.w));
      if (nt.w) begin
        chk(32'(loIdxNew), 32'(nt.n));
      end
    end else if (!rst) begin
      // no answer due: valid, fault and the step strobe must all be low
      chk(32'({resp.valid, resp.fault, loIdxWr}), 32'h0);
    end
  end

  // random strobes and requests, one cycle at a time
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (400) begin
      @(negedge clk_sys);
      chk(32'(bankEnable), 32'(f));
      chk(32'(bankSelect), 32'(s));
      chk(32'(stackBank), 32'(sb));
      chk(32'(selectRejected), 32'(rej));
      w = {$random(seed), $random(seed)};
      {serviceEnter, serviceReturn} = {w[2:0] == 3'h0, w[5:3] == 3'h0};
      {bankEnableWr, bankEnableData} = w[7:6];
      {bankSelectWr, bankSelectData} = {w[8] & w[9], w[13:10]};
      {stackBankWr, stackBankData} = {w[14] & w[15], w[17:16]};
      {loadWr, loadData} = w[22:18];
      w = {$random(seed), $random(seed)};
      req = dmb_req_t'(w[38:0]);
      req.mode = dmb_mode_t'(4'(w[63:32] % 13));
      req.loIdx = loIdxReg;
      if (req.mode == AM_DIR8) begin
        req.operand[0] = 1'b0;
      end
      if (req.valid) begin
        notes.push_back(predict(req));
      end
      // entry beats return, which beats a plain flag write
      if (serviceEnter) begin
        stk.push_front(f);
        if (stk.size() > 8) begin
          void'(stk.pop_back());
        end
        f = 1'b0;
      end else if (serviceReturn) begin
        f = (stk.size() > 0) ? stk.pop_front() : 1'b0;
      end else if (bankEnableWr) begin
        f = bankEnableData;
      end
      rej = bankSelectWr && !(bankSelectData inside {[4'h0:4'h3], 4'hF});
      if (bankSelectWr && !rej) begin
        s = bankSelectData;
      end
      if (stackBankWr) begin
        sb = stackBankData;
      end
    end
    @(negedge clk_sys);
    {req.valid, bankSelectWr, bankEnableWr, stackBankWr} = 4'h0;
    {serviceEnter, serviceReturn, loadWr} = 3'h0;
    repeat (3) @(negedge clk_sys);
    chk(32'(notes.size()), 32'h0);
    print_verdict();
  end

  // about 420 cycles are needed; give 1000
  initial begin
    #40000;
    miscompares++;
    print_verdict();
  end
endmodule : tb_top
